// file: src/hci_regs.svh
// register offsets, field positions and reset values of the overlay
// assumes a 32-bit word per register, decoded on byte address bits 7:0
`ifndef HCI_REGS_SVH
`define HCI_REGS_SVH
`define HCI_A_LOCK 8'h00
`define HCI_A_STYLE 8'h04
`define HCI_A_CMODE 8'h08
`define HCI_A_XH 8'h0C
`define HCI_A_XL 8'h10
`define HCI_A_YH 8'h14
`define HCI_A_YL 8'h18
`define HCI_A_OX 8'h1C
`define HCI_A_OY 8'h20
`define HCI_A_SEGH 8'h24
`define HCI_A_SEGL 8'h28
`define HCI_A_FG 8'h2C
`define HCI_A_BG 8'h30
`define HCI_A_DST 8'h34
`define HCI_A_IBASE 8'h38
`define HCI_A_ICOL 8'h3C
`define HCI_A_ICTL 8'h40
`define HCI_A_IXA 8'h44
`define HCI_A_IXB 8'h48
`define HCI_A_IYA 8'h4C
`define HCI_A_IYB 8'h50
`define HCI_A_DCFG 8'h54
`define HCI_A_WID 8'h58
`define HCI_A_HGT 8'h5C
`define HCI_A_STAT 8'h60
`define HCI_UNLOCK_KEY 8'hA0
`define HCI_STYLE_BIT 4
`define HCI_CUR_DST_BIT 7
`define HCI_ICN_DST_BIT 6
`define HCI_ICN_TRN_BIT 1
`define HCI_ICN_DBLX_BIT 2
`define HCI_ICN_DBLY_BIT 3
`define HCI_IMG_SPAN 12'h040
`define HCI_IMG_DBL 12'h080
`define HCI_LAST_WORD 10'h3FF
`define HCI_RST_WID 11'h400
`define HCI_RST_HGT 11'h300
`define HCI_OKAY 2'h0
`define HCI_SLVERR 2'h2
`endif

// file: src/hci_pkg.sv
// types of the cursor and icon overlay: bus, memory, pixel and state
// assumes one clock; all carriers are packed structs
package hci_pkg;
  typedef struct packed {
    logic awvalid; logic [31:0] awaddr; logic wvalid; logic [31:0] wdata;
    logic [3:0] wstrb; logic bready; logic arvalid; logic [31:0] araddr;
    logic rready;
  } hci_axi_req_t;
  typedef struct packed {
    logic awready; logic wready; logic bvalid; logic [1:0] bresp;
    logic arready; logic rvalid; logic [31:0] rdata; logic [1:0] rresp;
  } hci_axi_rsp_t;
  typedef struct packed {logic req; logic [20:0] addr;} hci_mem_req_t;
  typedef struct packed {logic ack; logic [15:0] data;} hci_mem_rsp_t;
  typedef struct packed {
    logic valid; logic fs; logic sel; logic [10:0] x; logic [10:0] y;
    logic [23:0] rgb;
  } hci_pix_t;
  typedef enum logic [0:0] {HCI_F_IDLE = 1'b0, HCI_F_RUN = 1'b1} hci_fetch_t;
  typedef struct packed {
    logic awg; logic wg; logic [7:0] aw_a; logic [31:0] w_d; logic [3:0] w_s;
    hci_axi_rsp_t rsp;
    logic [7:0] lock; logic [7:0] style; logic [7:0] cmode;
    logic [2:0] xh; logic [7:0] xl; logic [2:0] yh; logic [7:0] yl;
    logic [5:0] ox; logic [5:0] oy; logic [3:0] sh; logic [7:0] sl;
    logic [2:0][7:0] fg; logic [2:0][7:0] bg; logic [3:0] fp; logic [3:0] bp;
    logic [7:0] dst; logic [11:0] ibase; logic [11:0][7:0] icol; logic [3:0] ip;
    logic [7:0] ictl; logic [7:0] ixa; logic [2:0] ixb; logic [7:0] iya;
    logic [2:0] iyb; logic [1:0] dcfg; logic [10:0] wid; logic [10:0] hgt;
    logic [10:0] lcx; logic [10:0] lcy; logic [5:0] lox; logic [5:0] loy;
    logic [10:0] lix; logic [10:0] liy;
    hci_fetch_t fst; logic [9:0] fidx; hci_mem_req_t mem;
    logic [1023:0][15:0] img;
    hci_pix_t pout;
  } hci_st_t;
endpackage : hci_pkg

// file: src/hci_overlay.sv
// hardware cursor and icon overlay with its register file
// assumes pixel stream, memory port and bus all run on aclk
//
// What this block does
// - draw a 64x64 cursor from two 512-byte one-bit mask images
// - style bit 4 chooses first or second cursor decode convention
// - decode mask pairs to background, foreground, screen or inverted screen
// - foreground and background colours each held in three 8-bit registers
// - reading cursor mode resets colour pointers; writes fill low byte first
// - cursor off in legacy mode; enhanced mode uses mode bit 0 enable
// - cursor X and Y are 11-bit, split into 3-bit and 8-bit fields
// - clip cursor at right and bottom; Y past height hides it
// - cursor position taken up once per frame
// - fetch cursor as interleaved 16-bit first and second mask words
// - cursor image starts at a 1024-byte segment, 4+8 bit number
// - in dual image mode cursor destination bit 7 picks controller
// - icon shown in all modes; cursor above icon, both above screen
// - eight 1 KByte two-plane icons stored contiguously from icon base
// - four 24-bit icon colours via twelve auto-increment byte registers
// - icon enable bit 0; bits 6 to 4 select icon map
// - icon bit 1 makes code 11 transparent, else four colours
// - icon bits 2 and 3 double width and height by repetition
// - in dual image mode icon destination bit 6 picks controller
// - icon upper-left X and Y each held in a register pair
`timescale 1ns/1ps
`include "hci_regs.svh"

module hci_overlay (
  input logic aclk, // 25 MHz clock
  input logic aresetn, // synchronous reset, active low
  input hci_pkg::hci_axi_req_t axi_req, // AXI4-Lite master side
  output hci_pkg::hci_axi_rsp_t axi_rsp, // AXI4-Lite slave answers
  output hci_pkg::hci_mem_req_t mem_req, // word read request to display memory
  input hci_pkg::hci_mem_rsp_t mem_rsp, // word read acknowledge and data
  input hci_pkg::hci_pix_t pix_in, // pixel stream under the overlay
  output hci_pkg::hci_pix_t pix_out // pixel stream with overlay, one cycle later
);

  ////////////////////////////////////////////////////////////////////////
  // helpers

  // advance a colour stack pointer, wrapping after the last byte
  function automatic logic [3:0] ptr_adv(input logic [3:0] p, input logic [3:0] last);
    return (p == last) ? 4'h0 : p + 4'h1;
  endfunction : ptr_adv

  // fetch address of a word index: cursor words first, then the icon map
  function automatic logic [20:0] fetch_addr(input logic [9:0] i,
                                             input logic [11:0] seg,
                                             input logic [11:0] ib,
                                             input logic [2:0] isel);
    if (!i[9]) begin
      return {seg, i[8:0]};
    end
    return {ib, 9'h000} + {9'h000, isel, i[8:0]};
  endfunction : fetch_addr

  // two plane bits of one pixel; first plane word at even index, msb first
  function automatic logic [1:0] img_px(input logic [1023:0][15:0] im,
                                        input logic hi,
                                        input logic [5:0] r,
                                        input logic [5:0] c);
    logic [9:0] a0;
    logic [9:0] a1;
    a0 = {hi, r, c[5:4], 1'b0};
    a1 = {hi, r, c[5:4], 1'b1};
    return {im[a0][~c[3:0]], im[a1][~c[3:0]]};
  endfunction : img_px

  ////////////////////////////////////////////////////////////////////////
  // state

  hci_pkg::hci_st_t s_r;
  hci_pkg::hci_st_t s_nxt;

  logic we;
  logic ul;
  logic [7:0] wd;
  logic [31:0] rd;
  logic [11:0] cdx;
  logic [11:0] cdy;
  logic [11:0] ccol;
  logic [11:0] crow;
  logic [11:0] idx;
  logic [11:0] idy;
  logic [11:0] ilimx;
  logic [11:0] ilimy;
  logic [5:0] icx;
  logic [5:0] icy;
  logic act;
  logic cur_on;
  logic icn_on;
  logic [1:0] ccode;
  logic [1:0] icode;
  logic [3:0] ci;
  logic [23:0] under;
  logic [23:0] fgc;
  logic [23:0] bgc;
  logic [23:0] res;

  assign axi_rsp = s_r.rsp;
  assign mem_req = s_r.mem;
  assign pix_out = s_r.pout;

  // all state in one register; the image store is cleared by reset too
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_r <= '0;
      s_r.wid <= `HCI_RST_WID;
      s_r.hgt <= `HCI_RST_HGT;
    end else begin
      s_r <= s_nxt;
    end
  end

  always_comb begin
    s_nxt = s_r;
    we = 1'b0;
    ul = 1'b0;
    wd = 8'h00;
    rd = 32'h0000_0000;

    //////////////////////////////////////////////////////////////////////
    // bus write side: address and data may arrive in either order

    if (axi_req.awvalid && s_r.rsp.awready) begin
      s_nxt.awg = 1'b1;
      s_nxt.aw_a = axi_req.awaddr[7:0];
    end
    if (axi_req.wvalid && s_r.rsp.wready) begin
      s_nxt.wg = 1'b1;
      s_nxt.w_d = axi_req.wdata;
      s_nxt.w_s = axi_req.wstrb;
    end
    if (s_r.rsp.bvalid && axi_req.bready) begin
      s_nxt.rsp.bvalid = 1'b0;
    end

    // register write once both halves are held
    if (s_r.awg && s_r.wg && !s_r.rsp.bvalid) begin
      s_nxt.awg = 1'b0;
      s_nxt.wg = 1'b0;
      s_nxt.rsp.bvalid = 1'b1;
      s_nxt.rsp.bresp = `HCI_OKAY;
      we = s_r.w_s[0];
      wd = s_r.w_d[7:0];
      ul = we && (s_r.lock == `HCI_UNLOCK_KEY);
      case (s_r.aw_a)
        `HCI_A_LOCK: if (we) s_nxt.lock = wd;
        `HCI_A_STYLE: if (ul) s_nxt.style = wd;
        `HCI_A_CMODE: if (ul) s_nxt.cmode = wd;
        `HCI_A_XH: if (ul) s_nxt.xh = wd[2:0];
        `HCI_A_XL: if (ul) s_nxt.xl = wd;
        `HCI_A_YH: if (ul) s_nxt.yh = wd[2:0];
        `HCI_A_YL: if (ul) s_nxt.yl = wd;
        `HCI_A_OX: if (ul) s_nxt.ox = wd[5:0];
        `HCI_A_OY: if (ul) s_nxt.oy = wd[5:0];
        `HCI_A_SEGH: if (ul) s_nxt.sh = wd[3:0];
        `HCI_A_SEGL: if (ul) s_nxt.sl = wd;
        `HCI_A_FG: begin
          if (ul) begin
            s_nxt.fg[s_r.fp[1:0]] = wd;
            s_nxt.fp = ptr_adv(s_r.fp, 4'h2);
          end
        end
        `HCI_A_BG: begin
          if (ul) begin
            s_nxt.bg[s_r.bp[1:0]] = wd;
            s_nxt.bp = ptr_adv(s_r.bp, 4'h2);
          end
        end
        `HCI_A_DST: if (we) s_nxt.dst = wd;
        `HCI_A_IBASE: begin
          if (we) s_nxt.ibase = {s_r.w_s[1] ? s_r.w_d[11:8] : s_r.ibase[11:8], wd};
        end
        `HCI_A_ICOL: begin
          if (we) begin
            s_nxt.icol[s_r.ip] = wd;
            s_nxt.ip = ptr_adv(s_r.ip, 4'hB);
          end
        end
        `HCI_A_ICTL: if (we) s_nxt.ictl = wd;
        `HCI_A_IXA: if (we) s_nxt.ixa = wd;
        `HCI_A_IXB: if (we) s_nxt.ixb = wd[2:0];
        `HCI_A_IYA: if (we) s_nxt.iya = wd;
        `HCI_A_IYB: if (we) s_nxt.iyb = wd[2:0];
        `HCI_A_DCFG: if (we) s_nxt.dcfg = wd[1:0];
        `HCI_A_WID: begin
          if (we) s_nxt.wid = {s_r.w_s[1] ? s_r.w_d[10:8] : s_r.wid[10:8], wd};
        end
        `HCI_A_HGT: begin
          if (we) s_nxt.hgt = {s_r.w_s[1] ? s_r.w_d[10:8] : s_r.hgt[10:8], wd};
        end
        `HCI_A_STAT: ;
        default: s_nxt.rsp.bresp = `HCI_SLVERR;
      endcase
    end

    //////////////////////////////////////////////////////////////////////
    // bus read side: data one cycle after the address is taken

    if (s_r.rsp.rvalid && axi_req.rready) begin
      s_nxt.rsp.rvalid = 1'b0;
    end
    if (axi_req.arvalid && s_r.rsp.arready) begin
      s_nxt.rsp.rvalid = 1'b1;
      s_nxt.rsp.rresp = `HCI_OKAY;
      case (axi_req.araddr[7:0])
        `HCI_A_LOCK: rd[7:0] = s_r.lock;
        `HCI_A_STYLE: rd[7:0] = s_r.style;
        `HCI_A_CMODE: begin
          rd[7:0] = s_r.cmode;
          s_nxt.fp = 4'h0;
          s_nxt.bp = 4'h0;
        end
        `HCI_A_XH: rd[2:0] = s_r.xh;
        `HCI_A_XL: rd[7:0] = s_r.xl;
        `HCI_A_YH: rd[2:0] = s_r.yh;
        `HCI_A_YL: rd[7:0] = s_r.yl;
        `HCI_A_OX: rd[5:0] = s_r.ox;
        `HCI_A_OY: rd[5:0] = s_r.oy;
        `HCI_A_SEGH: rd[3:0] = s_r.sh;
        `HCI_A_SEGL: rd[7:0] = s_r.sl;
        `HCI_A_FG: rd[7:0] = s_r.fg[s_r.fp[1:0]];
        `HCI_A_BG: rd[7:0] = s_r.bg[s_r.bp[1:0]];
        `HCI_A_DST: rd[7:0] = s_r.dst;
        `HCI_A_IBASE: rd[11:0] = s_r.ibase;
        `HCI_A_ICOL: rd[7:0] = s_r.icol[s_r.ip];
        `HCI_A_ICTL: begin
          rd[7:0] = s_r.ictl;
          s_nxt.ip = 4'h0;
        end
        `HCI_A_IXA: rd[7:0] = s_r.ixa;
        `HCI_A_IXB: rd[2:0] = s_r.ixb;
        `HCI_A_IYA: rd[7:0] = s_r.iya;
        `HCI_A_IYB: rd[2:0] = s_r.iyb;
        `HCI_A_DCFG: rd[1:0] = s_r.dcfg;
        `HCI_A_WID: rd[10:0] = s_r.wid;
        `HCI_A_HGT: rd[10:0] = s_r.hgt;
        // live fetch state and the three pointers
        `HCI_A_STAT: rd[13:0] = {s_r.ip, s_r.bp[1:0], s_r.fp[1:0], s_r.fidx[9:5], s_r.fst};
        default: s_nxt.rsp.rresp = `HCI_SLVERR;
      endcase
      s_nxt.rsp.rdata = rd;
    end

    // ready flags registered from the next held state
    s_nxt.rsp.awready = !s_nxt.awg && !s_nxt.rsp.bvalid;
    s_nxt.rsp.wready = !s_nxt.wg && !s_nxt.rsp.bvalid;
    s_nxt.rsp.arready = !s_nxt.rsp.rvalid;

    //////////////////////////////////////////////////////////////////////
    // frame start: latch positions and refetch both images

    if (pix_in.fs) begin
      s_nxt.lcx = {s_r.xh, s_r.xl};
      s_nxt.lcy = {s_r.yh, s_r.yl};
      s_nxt.lox = s_r.ox;
      s_nxt.loy = s_r.oy;
      s_nxt.lix = {s_r.ixb, s_r.ixa};
      s_nxt.liy = {s_r.iyb, s_r.iya};
    end

    unique case (s_r.fst)
      hci_pkg::HCI_F_IDLE: begin
        if (pix_in.fs) begin
          s_nxt.fst = hci_pkg::HCI_F_RUN;
          s_nxt.fidx = 10'h000;
          s_nxt.mem.req = 1'b1;
          s_nxt.mem.addr = fetch_addr(10'h000, {s_r.sh, s_r.sl}, s_r.ibase,
                                      s_r.ictl[6:4]);
        end
      end
      hci_pkg::HCI_F_RUN: begin
        if (mem_rsp.ack) begin
          s_nxt.img[s_r.fidx] = mem_rsp.data;
          if (s_r.fidx == `HCI_LAST_WORD) begin
            s_nxt.fst = hci_pkg::HCI_F_IDLE;
            s_nxt.mem.req = 1'b0;
          end else begin
            s_nxt.fidx = s_r.fidx + 10'h001;
            s_nxt.mem.addr = fetch_addr(s_nxt.fidx, {s_r.sh, s_r.sl}, s_r.ibase,
                                        s_r.ictl[6:4]);
          end
        end
      end
    endcase

    //////////////////////////////////////////////////////////////////////
    // pixel overlay

    // only the active area takes overlay
    act = (pix_in.x < s_r.wid) && (pix_in.y < s_r.hgt);

    // offsets skip leading columns and rows
    cdx = {1'b0, pix_in.x} - {1'b0, s_r.lcx};
    cdy = {1'b0, pix_in.y} - {1'b0, s_r.lcy};
    ccol = cdx + {6'h00, s_r.lox};
    crow = cdy + {6'h00, s_r.loy};

    cur_on = act && s_r.cmode[0] && s_r.dcfg[0] && (s_r.lcy < s_r.hgt)
             && (!s_r.dcfg[1] || (s_r.dst[`HCI_CUR_DST_BIT] == pix_in.sel))
             && !cdx[11] && (ccol < `HCI_IMG_SPAN)
             && !cdy[11] && (crow < `HCI_IMG_SPAN);
    ccode = img_px(s_r.img, 1'b0, crow[5:0], ccol[5:0]);

    idx = {1'b0, pix_in.x} - {1'b0, s_r.lix};
    idy = {1'b0, pix_in.y} - {1'b0, s_r.liy};
    ilimx = s_r.ictl[`HCI_ICN_DBLX_BIT] ? `HCI_IMG_DBL : `HCI_IMG_SPAN;
    ilimy = s_r.ictl[`HCI_ICN_DBLY_BIT] ? `HCI_IMG_DBL : `HCI_IMG_SPAN;
    icx = s_r.ictl[`HCI_ICN_DBLX_BIT] ? idx[6:1] : idx[5:0];
    icy = s_r.ictl[`HCI_ICN_DBLY_BIT] ? idy[6:1] : idy[5:0];

    icn_on = act && s_r.ictl[0]
             && (!s_r.dcfg[1] || (s_r.dst[`HCI_ICN_DST_BIT] == pix_in.sel))
             && !idx[11] && (idx < ilimx) && !idy[11] && (idy < ilimy);
    icode = img_px(s_r.img, 1'b1, icy, icx);
    ci = {1'b0, icode, 1'b0} + {2'b00, icode};

    under = pix_in.rgb;
    if (icn_on && !(s_r.ictl[`HCI_ICN_TRN_BIT] && (icode == 2'b11))) begin
      under = {s_r.icol[ci + 4'h2], s_r.icol[ci + 4'h1], s_r.icol[ci]};
    end

    fgc = {s_r.fg[2], s_r.fg[1], s_r.fg[0]};
    bgc = {s_r.bg[2], s_r.bg[1], s_r.bg[0]};
    res = under;
    if (cur_on) begin
      if (!s_r.style[`HCI_STYLE_BIT]) begin
        unique case (ccode)
          2'b00: res = bgc;
          2'b01: res = fgc;
          2'b10: res = under;
          2'b11: res = ~under;
        endcase
      end else begin
        unique case (ccode)
          2'b00, 2'b01: res = under;
          2'b10: res = bgc;
          2'b11: res = fgc;
        endcase
      end
    end

    // registered pixel out; narrow depths use the low bits
    s_nxt.pout = pix_in;
    s_nxt.pout.rgb = res;
  end

endmodule : hci_overlay

// file: bench/hci_overlay_properties.sv
// port checker of the overlay: bus answers, fetch order, pixel path
// assumes one clock aclk and a synchronous active-low aresetn
`timescale 1ns/1ps
`include "hci_regs.svh"

module hci_overlay_properties (
  input logic aclk, // clock
  input logic aresetn, // reset, active low
  input hci_pkg::hci_axi_req_t axi_req, // bus requests
  input hci_pkg::hci_axi_rsp_t axi_rsp, // bus answers
  input hci_pkg::hci_mem_req_t mem_req, // memory requests
  input hci_pkg::hci_mem_rsp_t mem_rsp, // memory answers
  input hci_pkg::hci_pix_t pix_in, // stream in
  input hci_pkg::hci_pix_t pix_out // stream out
);
  logic [10:0] cnt_r; // words taken in this fetch
  logic [1:0] up_r; // edges since reset; the first two are exempt
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  //////////////////////////////////////////////////////////////////////////////
  // count acknowledged words and edges out of reset
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_r <= 11'h000;
      up_r <= 2'h0;
    end else begin
      cnt_r <= mem_req.req ? cnt_r + {10'h000, mem_rsp.ack} : 11'h000;
      up_r <= {up_r[0], 1'b1};
    end
  end
  //////////////////////////////////////////////////////////////////////////////
  property p_pix_pass;
    up_r[1] |-> pix_out.valid == $past(pix_in.valid) && pix_out.x == $past(pix_in.x)
      && pix_out.y == $past(pix_in.y) && pix_out.sel == $past(pix_in.sel);
  endproperty
  a_pix_pass: assert property (p_pix_pass) else $error("pixel not one cycle late");
  property p_fetch_go;
    up_r[1] && pix_in.fs && !mem_req.req |=> mem_req.req;
  endproperty
  a_fetch_go: assert property (p_fetch_go) else $error("no fetch at frame start");
  property p_base;
    $rose(mem_req.req) |-> mem_req.addr[8:0] == 9'h000;
  endproperty
  a_base: assert property (p_base) else $error("cursor image not aligned");
  property p_hold;
    mem_req.req && !mem_rsp.ack |=> mem_req.req && $stable(mem_req.addr);
  endproperty
  a_hold: assert property (p_hold) else $error("word address moved early");
  property p_step;
    mem_req.req && mem_rsp.ack && mem_req.addr[8:0] != 9'h1FF
      |=> mem_req.req && mem_req.addr == $past(mem_req.addr) + 21'h000001;
  endproperty
  a_step: assert property (p_step) else $error("word order broken");
  property p_icon;
    mem_req.req && mem_rsp.ack && cnt_r == 11'h1FF |=> mem_req.req && mem_req.addr[8:0] == 9'h000;
  endproperty
  a_icon: assert property (p_icon) else $error("icon words not aligned");
  property p_len;
    $fell(mem_req.req) |-> cnt_r == 11'h400;
  endproperty
  a_len: assert property (p_len) else $error("fetch length wrong");
  property p_rd;
    $rose(axi_rsp.rvalid) |-> $past(axi_req.arvalid && axi_rsp.arready);
  endproperty
  a_rd: assert property (p_rd) else $error("read answer without request");
  property p_wr;
    $rose(axi_rsp.bvalid) |-> $past(!axi_rsp.awready && !axi_rsp.wready);
  endproperty
  a_wr: assert property (p_wr) else $error("write answer too early");
  property p_xh;
    axi_req.arvalid && axi_rsp.arready && axi_req.araddr[7:0] == `HCI_A_XH
      |=> axi_rsp.rvalid && axi_rsp.rdata[31:3] == 29'h0;
  endproperty
  a_xh: assert property (p_xh) else $error("upper x field wider than 3 bits");
  c_fetch: cover property ($fell(mem_req.req));
  c_slverr: cover property (axi_rsp.rvalid && axi_rsp.rresp == `HCI_SLVERR);
  c_wr: cover property (axi_rsp.bvalid && axi_rsp.bresp == `HCI_OKAY);
endmodule : hci_overlay_properties

bind hci_overlay hci_overlay_properties hci_overlay_properties_i (.aclk(aclk),
  .aresetn(aresetn), .axi_req(axi_req), .axi_rsp(axi_rsp), .mem_req(mem_req),
  .mem_rsp(mem_rsp), .pix_in(pix_in), .pix_out(pix_out));

// file: bench/hci_dispmem.sv
// display memory holding cursor masks and icon planes
// assumes word requests held until acknowledged
// row r of each image: first plane bit is r bit 0, second plane bit is r bit 1
`timescale 1ns/1ps

module hci_dispmem (
  input logic aclk, // clock
  input logic aresetn, // reset, active low
  input logic slow, // stretch every answer by three cycles
  input hci_pkg::hci_mem_req_t mem_req, // word request
  output hci_pkg::hci_mem_rsp_t mem_rsp // acknowledge and data
);
  logic [1:0] wait_r; // cycles left before the answer
  //////////////////////////////////////////////////////////////////////////////
  // interleaved planes
  // data is only good with ack; otherwise it toggles so a stale read shows
  always @(posedge aclk) begin
    mem_rsp.ack <= 1'b0;
    mem_rsp.data <= ~mem_rsp.data;
    if (!aresetn) begin
      mem_rsp.data <= 16'h0000;
    end
    if (!aresetn || !mem_req.req || mem_rsp.ack) begin
      wait_r <= slow ? 2'h3 : 2'h0;
    end else if (wait_r != 2'h0) begin
      wait_r <= wait_r - 2'h1;
    end else begin
      mem_rsp.ack <= 1'b1;
      mem_rsp.data <= mem_req.addr[0] ? {16{mem_req.addr[4]}} : {16{mem_req.addr[3]}};
    end
  end
endmodule : hci_dispmem

// file: bench/hci_overlay_tb.sv
// self-checking bench of the overlay: registers, fetch and pixel decode
// assumes the memory model beside the design and the bound port checker
`timescale 1ns/1ps
`include "hci_regs.svh"
`define CHK(g, e) \
  begin \
    check_count++; \
    if ((g) !== (e)) begin \
      error_cnt++; \
      $display("mismatch at %0t: got %h want %h", $time, (g), (e)); \
    end \
  end

module hci_overlay_tb;
  localparam logic [23:0] SCR = 24'h123456; // screen pixel under the overlay
  localparam logic [23:0] FGC = 24'hF0E0D0;
  localparam logic [23:0] BGC = 24'h0A0B0C;
  logic aclk;
  logic aresetn;
  logic slow;
  hci_pkg::hci_axi_req_t req;
  hci_pkg::hci_axi_rsp_t rsp;
  hci_pkg::hci_mem_req_t mreq;
  hci_pkg::hci_mem_rsp_t mrsp;
  hci_pkg::hci_pix_t pin;
  hci_pkg::hci_pix_t pout;
  logic [23:0] t [4];
  int error_cnt;
  int check_count;
  int cyc;
  int i;
  hci_overlay hci_overlay_i (.aclk(aclk), .aresetn(aresetn), .axi_req(req), .axi_rsp(rsp),
    .mem_req(mreq), .mem_rsp(mrsp), .pix_in(pin), .pix_out(pout));
  hci_dispmem hci_dispmem_i (.aclk(aclk), .aresetn(aresetn), .slow(slow), .mem_req(mreq),
    .mem_rsp(mrsp));
  //////////////////////////////////////////////////////////////////////////////
  // 25 MHz clock and a ceiling well above six fetches
  always #20 aclk = ~aclk;
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 40000) begin
      error_cnt++;
      tally_and_finish();
    end
  end
  //////////////////////////////////////////////////////////////////////////////
  // bus write; bready stays high for the whole run
  // waits for the answer however long it takes; only the ceiling ends a hang
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] eb = 2'h0);
    req.awvalid <= 1'b1;
    req.awaddr <= {24'h0, a};
    req.wvalid <= 1'b1;
    req.wdata <= d;
    do begin
      @(posedge aclk);
      if (req.awvalid && rsp.awready) req.awvalid <= 1'b0;
      if (req.wvalid && rsp.wready) req.wvalid <= 1'b0;
    end while (!rsp.bvalid);
    `CHK(rsp.bresp, eb)
  endtask : wr
  // bus read with expected data and response
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] eb = 2'h0);
    req.arvalid <= 1'b1;
    req.araddr <= {24'h0, a};
    do begin
      @(posedge aclk);
      if (req.arvalid && rsp.arready) req.arvalid <= 1'b0;
    end while (!rsp.rvalid);
    `CHK(rsp.rdata, e)
    `CHK(rsp.rresp, eb)
  endtask : rd
  // one pixel in, its overlaid colour checked one cycle later
  task automatic px(input logic s, input logic [10:0] x, input logic [10:0] y,
      input logic [23:0] e);
    pin.valid <= 1'b1;
    pin.sel <= s;
    pin.x <= x;
    pin.y <= y;
    pin.rgb <= SCR;
    @(posedge aclk);
    pin.valid <= 1'b0;
    @(posedge aclk);
    `CHK(pout.rgb, e)
  endtask : px
  // frame start, then wait for the image fetch to finish
  task automatic frame();
    pin.fs <= 1'b1;
    @(posedge aclk);
    pin.fs <= 1'b0;
    repeat (2) @(posedge aclk);
    while (mreq.req) @(posedge aclk);
  endtask : frame
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : tally_and_finish
  //////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    aclk = 1'b0;
    aresetn = 1'b0;
    slow = 1'b0;
    req = '0;
    pin = '0;
    req.wstrb = 4'hF;
    req.bready = 1'b1;
    req.rready = 1'b1;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    rd(`HCI_A_WID, 32'h400);
    rd(`HCI_A_HGT, 32'h300);
    rd(8'hFC, 32'h0, `HCI_SLVERR);
    wr(8'hFC, 32'h1, `HCI_SLVERR);
    wr(`HCI_A_XL, 32'h55);
    rd(`HCI_A_XL, 32'h0);
    wr(`HCI_A_LOCK, 32'hA0);
    wr(`HCI_A_XH, 32'hFF);
    rd(`HCI_A_XH, 32'h7);
    rd(`HCI_A_CMODE, 32'h0);
    for (i = 0; i < 3; i++) begin
      wr(`HCI_A_FG, {24'h0, FGC[8*i +: 8]});
      wr(`HCI_A_BG, {24'h0, BGC[8*i +: 8]});
    end
    rd(`HCI_A_CMODE, 32'h0);
    rd(`HCI_A_FG, 32'hD0);
    // first-style cursor at x 100, y 50
    wr(`HCI_A_DCFG, 32'h1);
    wr(`HCI_A_CMODE, 32'h1);
    wr(`HCI_A_XH, 32'h0);
    wr(`HCI_A_XL, 32'h64);
    wr(`HCI_A_YL, 32'h32);
    wr(`HCI_A_SEGL, 32'h3);
    frame();
    t = '{BGC, SCR, FGC, ~SCR};
    for (i = 0; i < 4; i++) begin
      px(1'b0, 11'h064 + 11'(i), 11'h032 + 11'(i), t[i]);
    end
    px(1'b0, 11'h063, 11'h032, SCR);
    px(1'b0, 11'h0A3, 11'h032, BGC);
    px(1'b0, 11'h0A4, 11'h032, SCR);
    // second style, one row skipped, clipped at the right edge; slow memory
    wr(`HCI_A_STYLE, 32'h10);
    wr(`HCI_A_OY, 32'h1);
    wr(`HCI_A_XH, 32'h3);
    wr(`HCI_A_XL, 32'hE8);
    slow <= 1'b1;
    frame();
    slow <= 1'b0;
    t = '{BGC, SCR, FGC, SCR};
    for (i = 0; i < 3; i++) begin
      px(1'b0, 11'h3FF, 11'h032 + 11'(i), t[i]);
    end
    px(1'b0, 11'h3FF, 11'h070, FGC);
    px(1'b0, 11'h3FF, 11'h071, SCR);
    // icon map 3 at 200,100; cursor moved below the active height
    rd(`HCI_A_ICTL, 32'h0);
    for (i = 0; i < 12; i++) begin
      wr(`HCI_A_ICOL, 32'h11 * (i / 3 + 1));
    end
    wr(`HCI_A_ICTL, 32'h31);
    wr(`HCI_A_IBASE, 32'h4);
    wr(`HCI_A_IXA, 32'hC8);
    wr(`HCI_A_IYA, 32'h64);
    wr(`HCI_A_YH, 32'h3);
    wr(`HCI_A_YL, 32'h0);
    frame();
    t = '{24'h111111, 24'h333333, 24'h222222, 24'h444444};
    for (i = 0; i < 4; i++) begin
      px(1'b0, 11'h0C8 + 11'(i), 11'h064 + 11'(i), t[i]);
    end
    px(1'b0, 11'h3FF, 11'h300, SCR);
    px(1'b0, 11'h108, 11'h064, SCR);
    // legacy mode: icon doubled and transparent, cursor hidden
    wr(`HCI_A_DCFG, 32'h0);
    wr(`HCI_A_YH, 32'h0);
    wr(`HCI_A_YL, 32'h32);
    wr(`HCI_A_ICTL, 32'h3F);
    frame();
    px(1'b0, 11'h3FF, 11'h032, SCR);
    px(1'b0, 11'h0C8, 11'h066, 24'h333333);
    px(1'b0, 11'h147, 11'h064, 24'h111111);
    px(1'b0, 11'h0C8, 11'h06A, SCR);
    // dual image: cursor over icon, both on the first controller, then both on the second
    wr(`HCI_A_DCFG, 32'h3);
    wr(`HCI_A_XH, 32'h1);
    wr(`HCI_A_XL, 32'h2C);
    wr(`HCI_A_YL, 32'h64);
    wr(`HCI_A_OY, 32'h0);
    frame();
    px(1'b0, 11'h12C, 11'h065, BGC);
    px(1'b0, 11'h12C, 11'h064, 24'h111111);
    px(1'b1, 11'h12C, 11'h065, SCR);
    wr(`HCI_A_XL, 32'h2D);
    px(1'b0, 11'h12C, 11'h065, BGC);
    wr(`HCI_A_DST, 32'hC0);
    frame();
    px(1'b1, 11'h12D, 11'h065, BGC);
    px(1'b0, 11'h12D, 11'h065, SCR);
    px(1'b1, 11'h0C8, 11'h066, 24'h333333);
    // relocked: cursor writes ignored again
    wr(`HCI_A_LOCK, 32'h0);
    wr(`HCI_A_XL, 32'h5);
    rd(`HCI_A_XL, 32'h2D);
    // status: fetch idle, last word group 31, all three pointers back at zero
    rd(`HCI_A_STAT, 32'h3E);
    tally_and_finish();
  end
endmodule : hci_overlay_tb
